// ---- inc/fcs_pkg.sv ----
// Constants, types and command codes of the flash command sequencer
// How it works
// - Each word program is preceded by the three-write unlock
// - Each erase is sent as a full six-write sequence
// - Upper data byte is don't-care but driven to a valid level
// - Query mode entered by unlock ending 98H at 5555H
// - Query mode lasts until the exit command
// - Identification mode left only by the exit command
// - Unlock is AAH at 5555H, 55H at 2AAAH, then A0H/80H/90H/98H
// - Erase writes four, five repeat unlock; sixth is 30H, 50H or 10H
// - Exit is F0H at any address or unlock ending F0H
package fcs_pkg;

    ////////////////////////////////////////////////////////////////////////
    localparam int CLK_MHZ = 40;
    localparam int T_WP_NS = 40;
    localparam int T_RC_NS = 90;
    localparam int WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
    localparam int RD_CYC = (T_RC_NS * CLK_MHZ + 999) / 1000;
    localparam int POLL_LIMIT_DEF = 2000000;

    ////////////////////////////////////////////////////////////////////////
    localparam int AW = 20;
    localparam int DW = 16;
    localparam int TOGGLE_BIT = 6;
    localparam int POLL_BIT = 7;

    localparam logic [AW-1:0] ADDR_UNLOCK1 = 20'h05555;
    localparam logic [AW-1:0] ADDR_UNLOCK2 = 20'h02AAA;
    localparam logic [AW-1:0] SECTOR_MASK = 20'hFF800;
    localparam logic [AW-1:0] BLOCK_MASK = 20'hF8000;
    localparam logic [DW-1:0] CODE_UNLOCK1 = 16'h00AA;
    localparam logic [DW-1:0] CODE_UNLOCK2 = 16'h0055;
    localparam logic [DW-1:0] CODE_PROGRAM = 16'h00A0;
    localparam logic [DW-1:0] CODE_ERASE = 16'h0080;
    localparam logic [DW-1:0] CODE_IDENT = 16'h0090;
    localparam logic [DW-1:0] CODE_QUERY = 16'h0098;
    localparam logic [DW-1:0] CODE_SECTOR = 16'h0030;
    localparam logic [DW-1:0] CODE_BLOCK = 16'h0050;
    localparam logic [DW-1:0] CODE_CHIP = 16'h0010;
    localparam logic [DW-1:0] CODE_EXIT = 16'h00F0;

    ////////////////////////////////////////////////////////////////////////
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ADDR = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_RDATA = 8'h10;
    localparam int CTRL_START = 8;
    localparam int ST_BUSY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_OK = 2;
    localparam int ST_TIMEOUT = 3;
    localparam int ST_BADOP = 4;

    typedef enum logic [3:0] {
        OP_READ = 4'h0,
        OP_PROGRAM = 4'h1,
        OP_SECTOR = 4'h2,
        OP_BLOCK = 4'h3,
        OP_CHIP = 4'h4,
        OP_IDENT = 4'h5,
        OP_QUERY = 4'h6,
        OP_EXIT = 4'h7,
        OP_EXIT3 = 4'h8
    } fcs_op_t;

    typedef enum logic [1:0] {M_IDLE, M_ISSUE, M_WAIT} fcs_mstate_t;
    typedef enum logic [2:0] {S_IDLE, S_SETUP, S_ACT, S_HOLD, S_GAP} fcs_sstate_t;

endpackage : fcs_pkg

// ---- inc/fcs_cyc_if.sv ----
// One flash bus cycle request between command engine and pin sequencer
`timescale 1ns/1ps
interface fcs_cyc_if;
    logic req;
    logic we;
    logic [19:0] addr;
    logic [15:0] wdata;
    logic done;
    logic [15:0] rdata;
    modport ctrl (output req, output we, output addr, output wdata, input done, input rdata);
    modport seq (input req, input we, input addr, input wdata, output done, output rdata);
endinterface : fcs_cyc_if

// ---- logic/fcs_pin_seq.sv ----
// Pin sequencer: one read or write cycle on the flash pins
`timescale 1ns/1ps
module fcs_pin_seq (
    input wire logic clk_i,
    input wire logic rst_i,
    fcs_cyc_if.seq cy,
    input wire logic [15:0] dq_i,
    output logic [15:0] dq_o,
    output logic dq_oe_o,
    output logic [19:0] addr_o,
    output logic ce_n_o,
    output logic oe_n_o,
    output logic we_n_o
);
    localparam logic [3:0] WP_N = 4'(fcs_pkg::WP_CYC - 1);
    localparam logic [3:0] RD_N = 4'(fcs_pkg::RD_CYC - 1);

    generate
        if (fcs_pkg::WP_CYC < 1 || fcs_pkg::WP_CYC > 16 || fcs_pkg::RD_CYC > 16) begin : g_chk
            $error("fcs_pin_seq: cycle counts out of range");
        end
    endgenerate

    fcs_pkg::fcs_sstate_t st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    logic we_q, we_d, ce_n_q, ce_n_d, oe_n_q, oe_n_d, wen_q, wen_d, oe_q, oe_d, done_q, done_d;
    logic [19:0] a_q, a_d;
    logic [15:0] dq_q, dq_d, rd_q, rd_d;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        we_d = we_q;
        ce_n_d = ce_n_q;
        oe_n_d = oe_n_q;
        wen_d = wen_q;
        oe_d = oe_q;
        a_d = a_q;
        dq_d = dq_q;
        rd_d = rd_q;
        done_d = 1'b0;
        unique case (st_q)
            fcs_pkg::S_IDLE: begin
                if (cy.req) begin
                    a_d = cy.addr;
                    dq_d = cy.wdata;
                    we_d = cy.we;
                    ce_n_d = 1'b0;
                    oe_d = cy.we;
                    st_d = fcs_pkg::S_SETUP;
                end
            end
            fcs_pkg::S_SETUP: begin
                // Output enable stays high for writes so the device never inhibits
                if (we_q) begin
                    wen_d = 1'b0;
                    cnt_d = WP_N;
                end else begin
                    oe_n_d = 1'b0;
                    cnt_d = RD_N;
                end
                st_d = fcs_pkg::S_ACT;
            end
            fcs_pkg::S_ACT: begin
                if (cnt_q == 4'h0) begin
                    if (we_q) begin
                        wen_d = 1'b1;
                    end else begin
                        rd_d = dq_i;
                        oe_n_d = 1'b1;
                    end
                    st_d = fcs_pkg::S_HOLD;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            fcs_pkg::S_HOLD: begin
                // Data held two cycles past the strobe rise for hold time
                ce_n_d = 1'b1;
                st_d = fcs_pkg::S_GAP;
            end
            fcs_pkg::S_GAP: begin
                oe_d = 1'b0;
                done_d = 1'b1;
                st_d = fcs_pkg::S_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= fcs_pkg::S_IDLE;
            cnt_q <= 4'h0;
            we_q <= 1'b0;
            ce_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            wen_q <= 1'b1;
            oe_q <= 1'b0;
            a_q <= 20'h00000;
            dq_q <= 16'h0000;
            rd_q <= 16'h0000;
            done_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            we_q <= we_d;
            ce_n_q <= ce_n_d;
            oe_n_q <= oe_n_d;
            wen_q <= wen_d;
            oe_q <= oe_d;
            a_q <= a_d;
            dq_q <= dq_d;
            rd_q <= rd_d;
            done_q <= done_d;
        end
    end

    assign cy.done = done_q;
    assign cy.rdata = rd_q;
    assign dq_o = dq_q;
    assign dq_oe_o = oe_q;
    assign addr_o = a_q;
    assign ce_n_o = ce_n_q;
    assign oe_n_o = oe_n_q;
    assign we_n_o = wen_q;

endmodule : fcs_pin_seq

// ---- logic/fcs_top.sv ----
// Flash command sequencer: Wishbone registers, command engine, status polling
`timescale 1ns/1ps
module fcs_top #(
    parameter int POLL_LIMIT = fcs_pkg::POLL_LIMIT_DEF
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [15:0] dq_i,
    output logic [15:0] dq_o,
    output logic dq_oe_o,
    output logic [19:0] addr_o,
    output logic ce_n_o,
    output logic oe_n_o,
    output logic we_n_o
);
    generate
        if (POLL_LIMIT < 2 || POLL_LIMIT > 16777215) begin : g_chk
            $error("fcs_top: POLL_LIMIT must be 2..2^24-1");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        end
        return r;
    endfunction : merge

    function automatic logic [2:0] n_writes(input logic [3:0] op);
        logic [2:0] n;
        unique case (op)
            fcs_pkg::OP_PROGRAM: n = 3'd4;
            fcs_pkg::OP_SECTOR, fcs_pkg::OP_BLOCK, fcs_pkg::OP_CHIP: n = 3'd6;
            fcs_pkg::OP_IDENT, fcs_pkg::OP_QUERY, fcs_pkg::OP_EXIT3: n = 3'd3;
            fcs_pkg::OP_EXIT: n = 3'd1;
            default: n = 3'd0;
        endcase
        return n;
    endfunction : n_writes

    function automatic logic [35:0] step_word(input logic [3:0] op, input logic [2:0] step,
                                              input logic [19:0] a, input logic [15:0] d);
        logic [19:0] sa;
        logic [15:0] sd;
        sa = fcs_pkg::ADDR_UNLOCK1;
        sd = fcs_pkg::CODE_UNLOCK1;
        if (op == fcs_pkg::OP_EXIT) begin
            sa = a;
            sd = fcs_pkg::CODE_EXIT;
        end else begin
            unique case (step)
                3'd1, 3'd4: begin
                    sa = fcs_pkg::ADDR_UNLOCK2;
                    sd = fcs_pkg::CODE_UNLOCK2;
                end
                3'd2: begin
                    unique case (op)
                        fcs_pkg::OP_PROGRAM: sd = fcs_pkg::CODE_PROGRAM;
                        fcs_pkg::OP_IDENT: sd = fcs_pkg::CODE_IDENT;
                        fcs_pkg::OP_QUERY: sd = fcs_pkg::CODE_QUERY;
                        fcs_pkg::OP_EXIT3: sd = fcs_pkg::CODE_EXIT;
                        default: sd = fcs_pkg::CODE_ERASE;
                    endcase
                end
                3'd3: begin
                    if (op == fcs_pkg::OP_PROGRAM) begin
                        sa = a;
                        sd = d;
                    end
                end
                3'd5: begin
                    unique case (op)
                        fcs_pkg::OP_SECTOR: begin
                            sa = a & fcs_pkg::SECTOR_MASK;
                            sd = fcs_pkg::CODE_SECTOR;
                        end
                        fcs_pkg::OP_BLOCK: begin
                            sa = a & fcs_pkg::BLOCK_MASK;
                            sd = fcs_pkg::CODE_BLOCK;
                        end
                        default: sd = fcs_pkg::CODE_CHIP;
                    endcase
                end
                default: ;
            endcase
        end
        return {sa, sd};
    endfunction : step_word

    ////////////////////////////////////////////////////////////////////////
    fcs_cyc_if cy ();

    fcs_pin_seq u_seq (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cy(cy.seq),
        .dq_i(dq_i),
        .dq_o(dq_o),
        .dq_oe_o(dq_oe_o),
        .addr_o(addr_o),
        .ce_n_o(ce_n_o),
        .oe_n_o(oe_n_o),
        .we_n_o(we_n_o)
    );

    fcs_pkg::fcs_mstate_t st_q, st_d;
    logic [3:0] op_q, op_d;
    logic [19:0] addr_q, addr_d;
    logic [15:0] wdata_q, wdata_d, rdata_q, rdata_d, prev_q, prev_d;
    logic [2:0] step_q, step_d;
    logic [23:0] npoll_q, npoll_d;
    logic have_prev_q, have_prev_d;
    logic done_q, done_d, ok_q, ok_d, tout_q, tout_d, bad_q, bad_d;
    logic ack_q, ack_d;
    logic [31:0] dat_q, dat_d;
    logic hit, wr, start, polls, is_write;
    logic [35:0] sw;

    assign hit = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr = hit & wb_we_i;
    assign start = wr && wb_adr_i == fcs_pkg::REG_CTRL && wb_sel_i[1] && wb_dat_i[fcs_pkg::CTRL_START];
    assign polls = op_q inside {fcs_pkg::OP_PROGRAM, fcs_pkg::OP_SECTOR, fcs_pkg::OP_BLOCK,
                                fcs_pkg::OP_CHIP};
    assign is_write = step_q < n_writes(op_q);
    assign sw = step_word(op_q, step_q, addr_q, wdata_q);

    // Write fields come from the step table, reads take the address register; the sequencer latches them
    assign cy.req = (st_q == fcs_pkg::M_ISSUE);
    assign cy.we = is_write;
    assign cy.addr = is_write ? sw[35:16] : addr_q;
    assign cy.wdata = sw[15:0];

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [31:0] t;
        t = 32'h00000000;
        st_d = st_q;
        op_d = op_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        rdata_d = rdata_q;
        prev_d = prev_q;
        step_d = step_q;
        npoll_d = npoll_q;
        have_prev_d = have_prev_q;
        done_d = done_q;
        ok_d = ok_q;
        tout_d = tout_q;
        bad_d = bad_q;
        ack_d = hit;
        dat_d = dat_q;
        if (hit && !wb_we_i) begin
            unique case (wb_adr_i)
                fcs_pkg::REG_CTRL: dat_d = {28'h0000000, op_q};
                fcs_pkg::REG_ADDR: dat_d = {12'h000, addr_q};
                fcs_pkg::REG_WDATA: dat_d = {16'h0000, wdata_q};
                fcs_pkg::REG_STATUS: dat_d = {27'h0000000, bad_q, tout_q, ok_q, done_q,
                                              st_q != fcs_pkg::M_IDLE};
                fcs_pkg::REG_RDATA: dat_d = {16'h0000, rdata_q};
                default: dat_d = 32'h00000000;
            endcase
        end
        // Settings are frozen while busy so a running sequence stays coherent
        if (wr && st_q == fcs_pkg::M_IDLE) begin
            unique case (wb_adr_i)
                fcs_pkg::REG_CTRL: begin
                    t = merge({28'h0000000, op_q}, wb_dat_i, wb_sel_i);
                    op_d = t[3:0];
                end
                fcs_pkg::REG_ADDR: begin
                    t = merge({12'h000, addr_q}, wb_dat_i, wb_sel_i);
                    addr_d = t[19:0];
                end
                fcs_pkg::REG_WDATA: begin
                    t = merge({16'h0000, wdata_q}, wb_dat_i, wb_sel_i);
                    wdata_d = t[15:0];
                end
                default: ;
            endcase
        end
        unique case (st_q)
            fcs_pkg::M_IDLE: begin
                if (start) begin
                    done_d = 1'b0;
                    ok_d = 1'b0;
                    tout_d = 1'b0;
                    step_d = 3'd0;
                    npoll_d = 24'h000000;
                    have_prev_d = 1'b0;
                    if (op_d > fcs_pkg::OP_EXIT3) begin
                        bad_d = 1'b1;
                        done_d = 1'b1;
                    end else begin
                        bad_d = 1'b0;
                        st_d = fcs_pkg::M_ISSUE;
                    end
                end
            end
            fcs_pkg::M_ISSUE: st_d = fcs_pkg::M_WAIT;
            fcs_pkg::M_WAIT: begin
                if (cy.done) begin
                    st_d = fcs_pkg::M_ISSUE;
                    if (is_write) begin
                        step_d = step_q + 3'd1;
                        if (step_q + 3'd1 == n_writes(op_q) && !polls) begin
                            st_d = fcs_pkg::M_IDLE;
                            done_d = 1'b1;
                            ok_d = 1'b1;
                        end
                    end else begin
                        rdata_d = cy.rdata;
                        if (!polls) begin
                            st_d = fcs_pkg::M_IDLE;
                            done_d = 1'b1;
                            ok_d = 1'b1;
                        end else if (have_prev_q && prev_q[fcs_pkg::TOGGLE_BIT]
                                     == cy.rdata[fcs_pkg::TOGGLE_BIT]) begin
                            st_d = fcs_pkg::M_IDLE;
                            done_d = 1'b1;
                            if (op_q == fcs_pkg::OP_PROGRAM) begin
                                ok_d = cy.rdata == wdata_q;
                            end else begin
                                ok_d = cy.rdata[fcs_pkg::POLL_BIT];
                            end
                        end else if (npoll_q == 24'(POLL_LIMIT - 1)) begin
                            st_d = fcs_pkg::M_IDLE;
                            done_d = 1'b1;
                            tout_d = 1'b1;
                        end else begin
                            // Polling begins only after the final write strobe
                            prev_d = cy.rdata;
                            have_prev_d = 1'b1;
                            npoll_d = npoll_q + 24'h000001;
                        end
                    end
                end
            end
            default: st_d = fcs_pkg::M_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= fcs_pkg::M_IDLE;
            op_q <= 4'h0;
            addr_q <= 20'h00000;
            wdata_q <= 16'hFFFF;
            rdata_q <= 16'h0000;
            prev_q <= 16'h0000;
            step_q <= 3'd0;
            npoll_q <= 24'h000000;
            have_prev_q <= 1'b0;
            done_q <= 1'b0;
            ok_q <= 1'b0;
            tout_q <= 1'b0;
            bad_q <= 1'b0;
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end else begin
            st_q <= st_d;
            op_q <= op_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            prev_q <= prev_d;
            step_q <= step_d;
            npoll_q <= npoll_d;
            have_prev_q <= have_prev_d;
            done_q <= done_d;
            ok_q <= ok_d;
            tout_q <= tout_d;
            bad_q <= bad_d;
            ack_q <= ack_d;
            dat_q <= dat_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

endmodule : fcs_top

// ---- verification/fcs_checker.sv ----
// Port checker for the flash command sequencer top
`timescale 1ns/1ps
module fcs_checker #(
    parameter int POLL_LIMIT = 20
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic [15:0] dq_o,
    input wire logic dq_oe_o,
    input wire logic [19:0] addr_o,
    input wire logic ce_n_o,
    input wire logic oe_n_o,
    input wire logic we_n_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_wr_pulse; !we_n_o ##1 we_n_o; endsequence
    sequence s_rd_pulse; !oe_n_o [*3] ##1 oe_n_o; endsequence
    ////////////////////////////////////////////////////////////////////////
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_answer: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("missing ack");
    a_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    a_strobe_gated: assert property (!we_n_o |-> !ce_n_o && oe_n_o)
        else $error("write strobe outside a clean write");
    a_host_float: assert property (!oe_n_o |-> !dq_oe_o)
        else $error("host drives data during a read");
    a_wr_width: assert property ($fell(we_n_o) |=> s_wr_pulse)
        else $error("write pulse width wrong");
    a_rd_width: assert property ($fell(oe_n_o) |=> s_rd_pulse)
        else $error("read pulse width wrong");
    a_wr_stable: assert property (!we_n_o |-> $stable(addr_o) && $stable(dq_o) && dq_oe_o)
        else $error("address or data moved in a write");
    a_idle_quiet: assert property (ce_n_o |-> we_n_o && oe_n_o)
        else $error("strobe while deselected");
endmodule : fcs_checker
bind fcs_top fcs_checker #(.POLL_LIMIT(POLL_LIMIT)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .dq_o(dq_o),
    .dq_oe_o(dq_oe_o), .addr_o(addr_o), .ce_n_o(ce_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o));

// ---- verification/fcs_flash_model.sv ----
// Behavioural model of the parallel flash on the far side of the pins
`timescale 1ns/1ps
module fcs_flash_model #(
    parameter logic [15:0] MAKER_CODE = 16'h1357, // Arbitrary value
    parameter logic [15:0] PART_CODE = 16'h2468, // Arbitrary value
    parameter int BUSY_CYC = 60
) (
    input wire logic clk_i,
    input wire logic [15:0] dq_i,
    input wire logic [19:0] addr_i,
    input wire logic ce_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    output logic [15:0] dq_o
);
    logic [15:0] mem [int];
    logic [15:0] rd, wd, pd;
    logic [15:0] last = 16'h0000;
    logic we_q = 1'b1;
    logic ce_q = 1'b1;
    logic oe_q = 1'b1;
    logic tog = 1'b0;
    logic ers = 1'b0;
    logic [7:0] lo;
    int step = 0;
    int busy = 0;
    int mode = 0;
    int k;
    int msk;
    ////////////////////////////////////////////////////////////////////////
    always @* begin
        rd = mem.exists(int'(addr_i)) ? mem[int'(addr_i)] : 16'hFFFF;
        if (busy > 0) rd = {8'h00, ers ? 1'b0 : ~pd[7], tog, 6'h00};
        else if (mode == 1) rd = (addr_i == 20'h0) ? MAKER_CODE : PART_CODE;
        else if (mode == 2) rd = (addr_i == 20'h10) ? 16'h0051 : 16'h0000;
        // Released bus shows inverted data so a stale value never passes
        dq_o = (!ce_n_i && !oe_n_i && we_n_i) ? rd : ~last;
    end
    always @(posedge clk_i) begin
        we_q <= we_n_i;
        ce_q <= ce_n_i;
        oe_q <= oe_n_i;
        if (!ce_n_i && !oe_n_i) last <= rd;
        if (!oe_q && oe_n_i && busy > 0) tog <= ~tog;
        if (busy > 0) busy <= busy - 1;
        if (!we_q && !ce_q && oe_q && we_n_i && busy == 0) begin
            wd = dq_i;
            lo = wd[7:0];
            k = int'(addr_i);
            step <= 0;
            if (lo == 8'hF0 && step != 3) mode <= 0;
            case (step)
                0: if (lo == 8'hAA && k == 'h5555) step <= 1;
                1: if (lo == 8'h55 && k == 'h2AAA) step <= 2;
                2: if (k == 'h5555) begin
                    if (lo == 8'hA0) step <= 3;
                    if (lo == 8'h80) step <= 4;
                    if (lo == 8'h90) mode <= 1;
                    if (lo == 8'h98) mode <= 2;
                end
                3: begin
                    mem[k] = (mem.exists(k) ? mem[k] : 16'hFFFF) & wd;
                    pd <= wd;
                    ers <= 1'b0;
                    busy <= BUSY_CYC;
                end
                4: if (lo == 8'hAA && k == 'h5555) step <= 5;
                5: if (lo == 8'h55 && k == 'h2AAA) step <= 6;
                default: if (lo == 8'h30 || lo == 8'h50 || (lo == 8'h10 && k == 'h5555)) begin
                    msk = (lo == 8'h30) ? 'hFF800 : 'hF8000;
                    foreach (mem[i]) if (lo == 8'h10 || ((i ^ k) & msk) == 0) mem[i] = 16'hFFFF;
                    ers <= 1'b1;
                    busy <= BUSY_CYC;
                end
            endcase
        end
    end
endmodule : fcs_flash_model

// ---- verification/fcs_top_tb_top.sv ----
// Self-checking bench: register-level operations against the flash model
`timescale 1ns/1ps
module fcs_top_tb_top;
    localparam logic [15:0] MAKER = 16'h1357;
    localparam logic [15:0] PART = 16'h2468;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o, rv;
    logic wb_ack_o, dq_oe_o, ce_n_o, oe_n_o, we_n_o;
    logic [15:0] dq_o, dq_i, fl_dq;
    logic [19:0] addr_o;
    int bad_count = 0;
    int checks_done = 0;
    always #12.5 clk_i = ~clk_i;
    assign dq_i = dq_oe_o ? dq_o : fl_dq;
    fcs_top #(.POLL_LIMIT(20)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dq_i(dq_i),
        .dq_o(dq_o), .dq_oe_o(dq_oe_o), .addr_o(addr_o), .ce_n_o(ce_n_o), .oe_n_o(oe_n_o),
        .we_n_o(we_n_o));
    fcs_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART), .BUSY_CYC(60)) u_flash (
        .clk_i(clk_i), .dq_i(dq_i), .addr_i(addr_o), .ce_n_i(ce_n_o), .oe_n_i(oe_n_o),
        .we_n_i(we_n_o), .dq_o(fl_dq));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // Held until the ack edge, then released for one idle cycle
    // No cycle count assumed: only the watchdog ends a lost answer
    task automatic wb_io(input logic w, input logic [7:0] a, input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rv = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb_io
    task automatic run_op(input logic [3:0] op, input logic [19:0] a, input logic [15:0] d);
        int n;
        n = 0;
        wb_io(1'b1, 8'h04, {12'h000, a});
        wb_io(1'b1, 8'h08, {16'h0000, d});
        wb_io(1'b1, 8'h00, {23'h0, 1'b1, 4'h0, op});
        do begin
            wb_io(1'b0, 8'h0C, 32'h0);
            n++;
        end while (rv[1] !== 1'b1 && n < 400);
        // An operation that never finishes counts against the run
        if (rv[1] !== 1'b1) begin
            bad_count++;
            $display("wrong value at %0t: operation never finished", $time);
        end
    endtask : run_op
    task automatic rd_word(input logic [19:0] a, input logic [15:0] exp);
        run_op(4'h0, a, 16'h0000);
        wb_io(1'b0, 8'h10, 32'h0);
        check(rv, {16'h0000, exp});
    endtask : rd_word
    task automatic finish_test;
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #1500000;
        bad_count++;
        finish_test();
    end
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wb_io(1'b0, 8'h08, 32'h0);
        check(rv, 32'h0000FFFF);
        wb_io(1'b1, 8'h0C, 32'hFFFFFFFF);
        wb_io(1'b0, 8'h0C, 32'h0);
        check(rv, 32'h0);
        wb_io(1'b0, 8'h20, 32'h0);
        check(rv, 32'h0);
        run_op(4'h1, 20'h00123, 16'h1234);
        check(rv, 32'h6);
        run_op(4'h1, 20'h00923, 16'h5A5A);
        rd_word(20'h00123, 16'h1234);
        run_op(4'h2, 20'h00123, 16'h0000);
        check(rv, 32'h6);
        rd_word(20'h00123, 16'hFFFF);
        rd_word(20'h00923, 16'h5A5A);
        run_op(4'h3, 20'h00923, 16'h0000);
        check(rv, 32'h6);
        rd_word(20'h00923, 16'hFFFF);
        run_op(4'h1, 20'h40001, 16'h00C3);
        run_op(4'h4, 20'h00000, 16'h0000);
        check(rv, 32'h6);
        rd_word(20'h40001, 16'hFFFF);
        run_op(4'h5, 20'h00000, 16'h0000);
        rd_word(20'h00000, MAKER);
        rd_word(20'h00001, PART);
        run_op(4'h7, 20'h00000, 16'h0000);
        rd_word(20'h00000, 16'hFFFF);
        run_op(4'h6, 20'h00000, 16'h0000);
        rd_word(20'h00010, 16'h0051);
        run_op(4'h8, 20'h00000, 16'h0000);
        rd_word(20'h00010, 16'hFFFF);
        run_op(4'h9, 20'h00000, 16'h0000);
        check(rv, 32'h12);
        finish_test();
    end
endmodule : fcs_top_tb_top
